// *** design/pmd_defines.vh ***
// Constants of the program memory map decoder.
// Assumes inclusion by bare name from the decoder's Verilog files.
`ifndef PMD_DEFINES_VH
`define PMD_DEFINES_VH

`define PMD_PC_W 21
`define PMD_RESET_VEC 21'h000000
`define PMD_HI_VEC 21'h000008
`define PMD_LO_VEC 21'h000018
`define PMD_TOP_64K 21'h010000
`define PMD_TOP_96K 21'h018000
`define PMD_TOP_128K 21'h020000
`define PMD_CFG_BYTES 8
`define PMD_CFG_SPAN 21'h000008
`define PMD_BUSCFG_IDX 3'h4
`define PMD_BUSCFG_RESET 8'hF8
`define PMD_BIT_WAIT 7
`define PMD_BIT_WIDTH 6
`define PMD_BIT_MODE_HI 5
`define PMD_BIT_MODE_LO 4
`define PMD_BIT_SHIFT 3
`define PMD_MODE_MCU 2'h3
`define PMD_MODE_A12 2'h2
`define PMD_MODE_A16 2'h1
`define PMD_MODE_A20 2'h0
`define PMD_SRC_FLASH 2'h0
`define PMD_SRC_EXT 2'h1
`define PMD_SRC_ZERO 2'h2
`define PMD_REG_BUSCFG 4'h0
`define PMD_REG_STATUS 4'h1
`define PMD_REG_PC 4'h2
`define PMD_REG_TIMING 4'h3
`define PMD_REG_CFGW0 4'h4
`define PMD_REG_CFGW1 4'h5

`endif

// *** design/pmd_cfg_store.v ***
// Eight-byte store of the configuration bytes copied from flash.
// Assumes one writer and one reader on the same clock; read data registered.
`default_nettype none
module pmd_cfg_store
(
   input wire clk_sys,
   input wire writeEn,
   input wire [2:0] writeIdx,
   input wire [7:0] writeData,
   input wire [2:0] readIdx,
   output reg [7:0] readData
);
   reg [7:0] mem [0:7];

   always @(posedge clk_sys)
   begin
      if (writeEn)
      begin
         mem[writeIdx] <= writeData;
      end
      readData <= mem[readIdx];
   end
endmodule
`default_nettype wire

// *** design/pmd_addr_map.v ***
// Address classifier: picks flash, external bus or zero for a program address.
// Assumes configuration inputs stable while fetches are made.
`include "pmd_defines.vh"
`default_nettype none
module pmd_addr_map
(
   input wire [20:0] addr,
   input wire [20:0] memTop,
   input wire extMode,
   input wire shiftEn,
   input wire [1:0] modeSel,
   output reg [1:0] source,
   output reg [19:0] extAddr
);
   reg [20:0] offset;

   always @*
   begin
      offset = addr;
      if (shiftEn)
      begin
         offset = addr - memTop;
      end
      if (addr < memTop)
      begin
         source = `PMD_SRC_FLASH;
      end
      else if (extMode)
      begin
         source = `PMD_SRC_EXT;
      end
      else
      begin
         source = `PMD_SRC_ZERO;
      end
      case (modeSel)
         `PMD_MODE_A12: extAddr = {8'h00, offset[11:0]};
         `PMD_MODE_A16: extAddr = {4'h0, offset[15:0]};
         default: extAddr = offset[19:0];
      endcase
   end
endmodule
`default_nettype wire

// *** design/pmd_decoder.v ***
// Program memory map decoder with configuration load and Avalon-MM registers.
// Assumes flash answers a read within the cycle of the request, external
// memory raises extReady when its data are valid, and the core holds its
// fetch request until fetchValid.
// Bus masters hold each register request through two wait cycles.
`include "pmd_defines.vh"
`default_nettype none
module pmd_decoder
#(
   parameter [1:0] FLASH_SIZE = 2'h2,
   parameter PINS_100 = 1
)
(
   input wire clk_sys,
   input wire rst,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire fetchReq,
   input wire [1:0] fetchKind,
   input wire [20:0] fetchAddr,
   output reg fetchValid,
   output reg [15:0] fetchData,
   output reg [20:0] pcOut,
   output reg [20:0] flashAddr,
   output reg flashRead,
   input wire [15:0] flashData,
   output reg extRead,
   output reg [19:0] extAddrOut,
   output reg extWide,
   output reg extWaitDisable,
   output reg [1:0] extWaitSel,
   output reg extBusEnable,
   input wire extReady,
   input wire [15:0] extData,
   output reg cfgDone
);
   // ****************************************************************
   // Configuration state
   // ****************************************************************
   localparam ST_LOAD = 2'h0;
   localparam ST_IDLE = 2'h1;
   localparam ST_FLASH = 2'h2;
   localparam ST_EXT = 2'h3;

   reg [1:0] state;
   reg [2:0] loadIdx;
   reg loadWait;
   reg [7:0] busCfg;
   reg busCfgWritten;
   reg [1:0] timingSel;
   reg [2:0] rdIdx;
   reg busPhase;
   reg [31:0] next_readdata;
   wire [7:0] cfgByte;
   wire [1:0] source;
   wire [19:0] mappedAddr;
   reg [20:0] memTop;
   wire [1:0] modeSel;
   wire extMode;
   wire cfgLoadWrite;
   wire [20:0] fetchWord;

   function [20:0] top_of;
      input [1:0] sizeCode;
      begin
         case (sizeCode)
            2'h0: top_of = `PMD_TOP_64K;
            2'h1: top_of = `PMD_TOP_96K;
            default: top_of = `PMD_TOP_128K;
         endcase
      end
   endfunction

   function [7:0] mask_cfg;
      input [7:0] raw;
      begin
         mask_cfg = {raw[7:3], 3'h0};
      end
   endfunction

   function [20:0] word_of;
      input [20:0] byteAddr;
      begin
         word_of = {byteAddr[20:1], 1'b0};
      end
   endfunction

   function is_vector;
      input [1:0] kind;
      begin
         is_vector = (kind == 2'h1) || (kind == 2'h2);
      end
   endfunction

   function bus_hit;
      input [3:0] addr;
      input [3:0] code;
      input strobe;
      input stall;
      begin
         bus_hit = strobe && !stall && (addr == code);
      end
   endfunction

   always @*
   begin
      memTop = top_of(FLASH_SIZE);
   end

   assign modeSel = PINS_100 ? busCfg[`PMD_BIT_MODE_HI:`PMD_BIT_MODE_LO] : `PMD_MODE_MCU;
   assign extMode = (modeSel != `PMD_MODE_MCU);
   assign cfgLoadWrite = (state == ST_LOAD) && loadWait;
   assign fetchWord = word_of(fetchAddr);

   pmd_cfg_store cfgStore
   (
      .clk_sys(clk_sys),
      .writeEn(cfgLoadWrite),
      .writeIdx(loadIdx),
      .writeData(loadIdx[0] ? flashData[15:8] : flashData[7:0]),
      .readIdx(rdIdx),
      .readData(cfgByte)
   );

   pmd_addr_map addrMap
   (
      .addr(fetchWord),
      .memTop(memTop),
      .extMode(extMode),
      .shiftEn(busCfg[`PMD_BIT_SHIFT]),
      .modeSel(modeSel),
      .source(source),
      .extAddr(mappedAddr)
   );

   // ****************************************************************
   // Fetch sequencing and configuration copy
   // ****************************************************************
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         state <= ST_LOAD;
         loadIdx <= 3'h0;
         loadWait <= 1'b0;
         busCfg <= `PMD_BUSCFG_RESET;
         busCfgWritten <= 1'b0;
         pcOut <= `PMD_RESET_VEC;
         flashAddr <= 21'h000000;
         flashRead <= 1'b0;
         extRead <= 1'b0;
         extAddrOut <= 20'h00000;
         fetchValid <= 1'b0;
         fetchData <= 16'h0000;
         cfgDone <= 1'b0;
      end
      else
      begin
         fetchValid <= 1'b0;
         flashRead <= 1'b0;
         case (state)
            ST_LOAD:
            begin
               // Reads words at top minus eight, low byte then high byte.
               if (!loadWait)
               begin
                  flashAddr <= memTop - `PMD_CFG_SPAN + {18'h00000, loadIdx[2:1], 1'b0};
                  flashRead <= 1'b1;
                  loadWait <= 1'b1;
               end
               else
               begin
                  loadWait <= 1'b0;
                  if (loadIdx == `PMD_BUSCFG_IDX && PINS_100 != 0)
                  begin
                     busCfg <= mask_cfg(flashData[7:0]);
                     busCfgWritten <= 1'b1;
                  end
                  if (loadIdx == 3'h7)
                  begin
                     state <= ST_IDLE;
                     cfgDone <= 1'b1;
                  end
                  loadIdx <= loadIdx + 3'h1;
               end
            end
            ST_IDLE:
            begin
               if (fetchReq && !fetchValid)
               begin
                  // Kind 1 and 2 select the interrupt vectors; 3 is plain.
                  case (fetchKind)
                     2'h1: pcOut <= `PMD_HI_VEC;
                     2'h2: pcOut <= `PMD_LO_VEC;
                     default: pcOut <= fetchWord;
                  endcase
                  if (is_vector(fetchKind))
                  begin
                     fetchValid <= 1'b1;
                     fetchData <= 16'h0000;
                  end
                  else if (source == `PMD_SRC_FLASH)
                  begin
                     flashAddr <= fetchWord;
                     flashRead <= 1'b1;
                     state <= ST_FLASH;
                  end
                  else if (source == `PMD_SRC_EXT)
                  begin
                     extAddrOut <= mappedAddr;
                     extRead <= 1'b1;
                     state <= ST_EXT;
                  end
                  else
                  begin
                     fetchValid <= 1'b1;
                     fetchData <= 16'h0000;
                  end
               end
            end
            ST_FLASH:
            begin
               fetchValid <= 1'b1;
               fetchData <= flashData;
               state <= ST_IDLE;
            end
            ST_EXT:
            begin
               if (extReady)
               begin
                  extRead <= 1'b0;
                  fetchValid <= 1'b1;
                  fetchData <= busCfg[`PMD_BIT_WIDTH] ? extData : {8'h00, extData[7:0]};
                  state <= ST_IDLE;
               end
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
         // Software writes to the five bits are ignored: in ST_LOAD, when PINS_100 is 0, and once the configuration copy has set busCfgWritten.
         if (bus_hit(avs_address, `PMD_REG_BUSCFG, avs_write, avs_waitrequest)
             && !busCfgWritten && PINS_100 != 0 && state != ST_LOAD)
         begin
            busCfg <= mask_cfg(avs_writedata[7:0]);
            busCfgWritten <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Bus side outputs
   // ****************************************************************
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         extWide <= 1'b0;
         extWaitDisable <= 1'b1;
         extWaitSel <= 2'h0;
         extBusEnable <= 1'b0;
      end
      else
      begin
         extWide <= busCfg[`PMD_BIT_WIDTH];
         extWaitDisable <= busCfg[`PMD_BIT_WAIT];
         extWaitSel <= busCfg[`PMD_BIT_WAIT] ? 2'h0 : timingSel;
         extBusEnable <= extMode;
      end
   end

   // ****************************************************************
   // Register read multiplexer
   // ****************************************************************
   always @*
   begin
      rdIdx = 3'h0;
      if (avs_address == `PMD_REG_CFGW1)
      begin
         rdIdx = `PMD_BUSCFG_IDX;
      end
   end

   always @*
   begin
      next_readdata = 32'h00000000;
      case (avs_address)
         `PMD_REG_BUSCFG: next_readdata = {24'h000000, busCfg};
         `PMD_REG_STATUS: next_readdata = {26'h0000000, busCfgWritten, cfgDone,
                                           extMode, PINS_100 != 0, state};
         `PMD_REG_PC: next_readdata = {11'h000, pcOut};
         `PMD_REG_TIMING: next_readdata = {30'h00000000, timingSel};
         `PMD_REG_CFGW0: next_readdata = {24'h000000, cfgByte};
         `PMD_REG_CFGW1: next_readdata = {24'h000000, cfgByte};
         default: next_readdata = 32'h00000000;
      endcase
   end

   // ****************************************************************
   // Avalon-MM register slave
   // ****************************************************************
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
         timingSel <= 2'h0;
         busPhase <= 1'b0;
      end
      else
      begin
         // Two wait cycles let the configuration store's registered read settle.
         // A write takes effect on the edge after the wait ends, while waitrequest is low.
         avs_waitrequest <= 1'b1;
         busPhase <= 1'b0;
         if ((avs_read || avs_write) && avs_waitrequest && !busPhase)
         begin
            busPhase <= 1'b1;
         end
         if (busPhase)
         begin
            avs_waitrequest <= 1'b0;
            if (avs_read)
            begin
               avs_readdata <= next_readdata;
            end
         end
         if (bus_hit(avs_address, `PMD_REG_TIMING, avs_write, avs_waitrequest))
         begin
            timingSel <= avs_writedata[1:0];
         end
      end
   end
endmodule
`default_nettype wire

// *** verif/pmd_decoder_properties.sv ***
// Concurrent checks on the decoder's top ports.
// Assumes the bench holds fetchReq and its qualifiers until fetchValid.
`default_nettype none
module pmd_decoder_properties
#(
   parameter [1:0] FLASH_SIZE = 2'h2
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic avs_read,
   input wire logic avs_waitrequest,
   input wire logic fetchReq,
   input wire logic [1:0] fetchKind,
   input wire logic [20:0] fetchAddr,
   input wire logic fetchValid,
   input wire logic [15:0] fetchData,
   input wire logic [20:0] pcOut,
   input wire logic [20:0] flashAddr,
   input wire logic flashRead,
   input wire logic extRead,
   input wire logic extBusEnable,
   input wire logic extWaitDisable,
   input wire logic [1:0] extWaitSel,
   input wire logic cfgDone
);
   localparam logic [20:0] TOP = (FLASH_SIZE == 2'h0) ? 21'h010000 :
      (FLASH_SIZE == 2'h1) ? 21'h018000 : 21'h020000;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   sequence cfg_load;
      !cfgDone ##[1:40] cfgDone;
   endsequence
   sequence bus_answer;
      avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   reset_pc_a:
      assert property ($fell(rst) |-> pcOut == 21'h0) else $error("pc not at reset vector");
   cfg_load_a:
      assert property ($fell(rst) |-> cfg_load) else $error("config copy late");
   cfg_addr_a:
      assert property (flashRead && !cfgDone |-> flashAddr >= TOP - 21'h8 && flashAddr < TOP)
         else $error("config read outside block");
   hi_vec_a:
      assert property (fetchValid && fetchKind == 2'h1 |=> pcOut == 21'h8) else $error("hi vector");
   lo_vec_a:
      assert property (fetchValid && fetchKind == 2'h2 |=> pcOut == 21'h18) else $error("lo vector");
   zero_read_a:
      assert property (fetchValid && fetchKind == 2'h0 && !extBusEnable && fetchAddr >= TOP
         |-> fetchData == 16'h0) else $error("missing zero read");
   mcu_noext_a:
      assert property (!extBusEnable |-> !extRead) else $error("external read in internal mode");
   ext_pick_a:
      assert property ($rose(extRead) |-> fetchReq && fetchAddr >= TOP) else $error("bad ext pick");
   flash_pick_a:
      assert property (flashRead && cfgDone |-> fetchReq && fetchAddr < TOP)
         else $error("bad flash pick");
   bus_ans_a:
      assert property ($rose(avs_read) |=> bus_answer) else $error("bus answer timing");
   wait_sel_a:
      assert property (extWaitDisable |-> extWaitSel == 2'h0) else $error("wait select set");
endmodule
bind pmd_decoder pmd_decoder_properties #(.FLASH_SIZE(FLASH_SIZE)) u_props (.clk_sys, .rst,
   .avs_read, .avs_waitrequest, .fetchReq, .fetchKind, .fetchAddr, .fetchValid, .fetchData,
   .pcOut, .flashAddr, .flashRead, .extRead, .extBusEnable, .extWaitDisable, .extWaitSel,
   .cfgDone);
`default_nettype wire

// *** verif/pmd_mem_model.sv ***
// Flash array and external program memory facing the decoder.
// Assumes a 64 Kbyte part; cfgByte is the stored bus configuration byte.
`default_nettype none
module pmd_mem_model
(
   input wire logic clk_sys,
   input wire logic [7:0] cfgByte,
   input wire logic slow,
   input wire logic flashRead,
   input wire logic [20:0] flashAddr,
   output logic [15:0] flashData,
   input wire logic extRead,
   input wire logic [19:0] extAddrOut,
   output logic extReady,
   output logic [15:0] extData
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] cnt = 3'h0;
   logic [15:0] word;
   function automatic logic [7:0] fb(input logic [20:0] a, input logic [7:0] c);
      fb = (a[15:0] == 16'hFFFC) ? c : (a[7:0] ^ 8'h5A);
   endfunction
   // Flash answers within the cycle of the read and shows the inverse otherwise.
   assign word = {fb(flashAddr | 21'h1, cfgByte), fb(flashAddr & ~21'h1, cfgByte)};
   assign flashData = flashRead ? word : ~word;
   always @(posedge clk_sys)
   begin
      extReady <= 1'b0;
      extData <= ~extData;
      cnt <= extRead ? cnt + 3'h1 : 3'h0;
      if (extRead && !extReady && cnt >= (slow ? 3'h4 : 3'h0))
      begin
         extReady <= 1'b1;
         extData <= extAddrOut[15:0] ^ 16'hC3A5;
      end
   end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the decoder on a 64 Kbyte, 100-pin build.
// Assumes the memory model and the bound checker are compiled alongside.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic avs_read = 1'b0, avs_write = 1'b0, fetchReq = 1'b0, slow = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [1:0] fetchKind = 2'h0;
   logic [20:0] fetchAddr = 21'h0;
   logic [7:0] cfgByte = 8'hF8;
   logic [31:0] avs_readdata, r;
   logic avs_waitrequest, fetchValid, flashRead, extRead, extWide, extWaitDisable;
   logic extBusEnable, extReady, cfgDone;
   logic [15:0] fetchData, flashData, extData, q;
   logic [20:0] pcOut, flashAddr;
   logic [19:0] extAddrOut, ea;
   logic [1:0] extWaitSel;
   int bad_count = 0, n_tests = 0;
   always #4 clk_sys = ~clk_sys;
   pmd_decoder #(.FLASH_SIZE(2'h0), .PINS_100(1)) u_dut (.clk_sys, .rst, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .fetchReq,
      .fetchKind, .fetchAddr, .fetchValid, .fetchData, .pcOut, .flashAddr, .flashRead,
      .flashData, .extRead, .extAddrOut, .extWide, .extWaitDisable, .extWaitSel,
      .extBusEnable, .extReady, .extData, .cfgDone);
   pmd_mem_model u_mem (.clk_sys, .cfgByte, .slow, .flashRead, .flashAddr, .flashData,
      .extRead, .extAddrOut, .extReady, .extData);
   task automatic end_sim;
      if (bad_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 50)
      begin
         @(posedge clk_sys);
         n++;
      end
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n == 50)
         bad_count++;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(r, exp);
   endtask
   task automatic fetch(input logic [1:0] k, input logic [20:0] a);
      int n;
      n = 0;
      fetchKind <= k;
      fetchAddr <= a;
      fetchReq <= 1'b1;
      @(posedge clk_sys);
      while (fetchValid !== 1'b1 && n < 50)
      begin
         if (extRead === 1'b1)
            ea = extAddrOut;
         @(posedge clk_sys);
         n++;
      end
      q = fetchData;
      fetchReq <= 1'b0;
      if (n == 50)
         bad_count++;
      @(posedge clk_sys);
   endtask
   task automatic do_reset(input logic [7:0] c);
      int n;
      n = 0;
      cfgByte <= c;
      rst <= 1'b1;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk(pcOut, 32'h0);
      while (cfgDone !== 1'b1 && n < 100)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (n == 100)
         bad_count++;
   endtask
   initial
   begin
      for (int m = 0; m < 4; m++)
      begin
         do_reset({2'b10, m[1:0], 4'h0});
         chk(extBusEnable, m != 3);
         chk({extWide, extWaitDisable}, 32'h1);
         fetch(2'h0, 21'h010010);
         chk(q, (m == 3) ? 32'h0 : 32'hB5);
      end
      do_reset(8'h4F);
      rd(4'h0, 32'h48);
      bus(1'b1, 4'h0, 32'h0);
      rd(4'h0, 32'h48);
      rd(4'h4, 32'hA2);
      rd(4'h5, 32'h4F);
      rd(4'h6, 32'h0);
      rd(4'h1, 32'h3D);
      chk({extWide, extWaitDisable, extBusEnable}, 32'h5);
      bus(1'b1, 4'h3, 32'h2);
      rd(4'h3, 32'h2);
      chk(extWaitSel, 32'h2);
      fetch(2'h0, 21'h000100);
      chk(q, 32'h5B5A);
      fetch(2'h0, 21'h010034);
      chk({ea, q}, 36'h00034C391);
      slow <= 1'b1;
      fetch(2'h0, 21'h1F0002);
      chk({ea, q}, 36'hE0002C3A7);
      fetch(2'h1, 21'h000200);
      chk({pcOut, q}, 37'h00080000);
      fetch(2'h2, 21'h000200);
      chk({pcOut, q}, 37'h00180000);
      rd(4'h2, 32'h18);
      end_sim;
   end
   initial
   begin
      #100000;
      bad_count++;
      end_sim;
   end
endmodule
`default_nettype wire
